/* hdl/ptc_pkg.sv */
package ptc_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_LOWER_CTRL = 8'h00;
  localparam logic [7:0] ADDR_UPPER_CTRL = 8'h04;
  localparam logic [7:0] ADDR_LOWER_PER  = 8'h08;
  localparam logic [7:0] ADDR_UPPER_PER  = 8'h0C;
  localparam logic [7:0] ADDR_LOWER_CNT  = 8'h10;
  localparam logic [7:0] ADDR_UPPER_CNT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h20;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int BIT_COUNT_RUN    = 15;
  localparam int BIT_HALT_IDLE    = 13;
  localparam int BIT_GATE_EN      = 6;
  localparam int BIT_PRESC_HI     = 5;
  localparam int BIT_PRESC_LO     = 4;
  localparam int BIT_CASCADE      = 3;
  localparam int BIT_CLK_SRC      = 1;

  // Implemented bits; all others read zero
  localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;

  // ****************************************
  // Prescaler terminal counts
  // ****************************************
  localparam logic [1:0] PRESC_DIV1   = 2'h0;
  localparam logic [1:0] PRESC_DIV8   = 2'h1;
  localparam logic [1:0] PRESC_DIV64  = 2'h2;
  localparam logic [1:0] PRESC_DIV256 = 2'h3;
  localparam logic [7:0] PRESC_LIM1   = 8'h00;
  localparam logic [7:0] PRESC_LIM8   = 8'h07;
  localparam logic [7:0] PRESC_LIM64  = 8'h3F;
  localparam logic [7:0] PRESC_LIM256 = 8'hFF;

  // ****************************************
  // Interrupt status layout
  // ****************************************
  localparam int IRQ_LOWER = 0;
  localparam int IRQ_UPPER = 1;

endpackage

/* hdl/ptc_tick.sv */
`timescale 1ns/1ps
module ptc_tick
  import ptc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Configuration
  input  wire logic       run,
  input  wire logic       ext_sel,
  input  wire logic       gate_en,
  input  wire logic [1:0] presc_sel,
  // Pins
  input  wire logic       ext_pin,
  input  wire logic       gate_pin,
  // Events
  output logic            tick,
  output logic            gate_fall
);

  typedef struct packed {
    logic       pin_q;
    logic       gate_q;
    logic [7:0] presc_cnt;
  } ptc_tick_s;

  ptc_tick_s r;
  ptc_tick_s next_r;
  logic      gated;
  logic      qual;
  logic [7:0] lim;

  always_comb
  begin
    next_r = r;
    tick = 1'b0;
    next_r.pin_q = ext_pin;
    next_r.gate_q = gate_pin;
    // Gate only meaningful on the internal clock
    gated = gate_en & ~ext_sel;
    // Pin edge is found on the system clock, never async
    qual = (ext_sel ? (ext_pin & ~r.pin_q) : 1'b1) & (~gated | gate_pin);
    unique case (presc_sel)
      PRESC_DIV1:  lim = PRESC_LIM1;
      PRESC_DIV8:  lim = PRESC_LIM8;
      PRESC_DIV64: lim = PRESC_LIM64;
      PRESC_DIV256: lim = PRESC_LIM256;
    endcase
    if (!run)
    begin
      next_r.presc_cnt = 8'h00;
    end
    else if (qual)
    begin
      if (r.presc_cnt == lim)
      begin
        tick = 1'b1;
        next_r.presc_cnt = 8'h00;
      end
      else
      begin
        next_r.presc_cnt = r.presc_cnt + 8'h01;
      end
    end
    gate_fall = run & gated & r.gate_q & ~gate_pin;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

endmodule

/* hdl/ptc_count16.sv */
`timescale 1ns/1ps
module ptc_count16
  import ptc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // Control
  input  wire logic        inc,
  input  wire logic        clr,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  // Value
  output logic [15:0]      value
);

  typedef struct packed {
    logic [15:0] value;
  } ptc_cnt_s;

  ptc_cnt_s r;
  ptc_cnt_s next_r;

  always_comb
  begin
    next_r = r;
    // Software load beats the period reset
    if (load)
    begin
      next_r.value = load_val;
    end
    else if (clr)
    begin
      next_r.value = 16'h0000;
    end
    else if (inc)
    begin
      next_r.value = r.value + 16'h0001;
    end
    value = r.value;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

endmodule

/* hdl/ptc_timer_pair.sv */
//
// How it works
// - Lower run bit starts lower timer, or the whole pair when cascaded.
// - Halt-in-idle bit set stops the timer while the device idles.
// - Gate bit enables gated accumulation on internal clock only.
// - Two-bit prescale field divides by 1, 8, 64 or 256.
// - Cascade bit joins both halves into one 32-bit timer.
// - Lower clock-source bit selects rising edges of its external pin.
// - Upper clock-source bit selects its own pin, where that pin exists.
// - Upper run bit starts upper as independent 16-bit timer.
// - In cascade, upper run, gate, prescale, source bits do nothing.
// - Unimplemented control bits read zero and ignore writes.
// - Lower holds the low word, upper the high word in cascade.
// - Cascade uses lower clock and gate, flags through upper interrupt bit.
// - External counting is always synchronised to the system clock.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ptc_timer_pair
  import ptc_pkg::*;
#(
  parameter bit UPPER_PIN_PRESENT = 1'b1
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Device pins and power state
  input  wire logic        idle_mode,
  input  wire logic        lower_ext_clock_pin,
  input  wire logic        upper_ext_clock_pin,
  input  wire logic        lower_gate_pin,
  input  wire logic        upper_gate_pin,
  // Interrupt
  output logic             irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] lower_timer_control;
    logic [15:0] upper_timer_control;
    logic [15:0] lower_period;
    logic [15:0] upper_period;
    logic [1:0]  status;
    logic [1:0]  irq_en;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
  } ptc_pair_s;

  ptc_pair_s r;
  ptc_pair_s next_r;

  logic [15:0] lower_cnt;
  logic [15:0] upper_cnt;
  logic        lower_tick;
  logic        upper_tick;
  logic        lower_gfall;
  logic        upper_gfall;
  logic        cascade;
  logic        lower_run;
  logic        upper_run;
  logic        upper_src;
  logic        upper_pin;
  logic        access;
  logic        wr_go;
  logic        addr_ok;
  logic        lower_inc;
  logic        lower_clr;
  logic        upper_inc;
  logic        upper_clr;
  logic        lower_load;
  logic        upper_load;
  logic        match32;
  logic        lower_match;
  logic        upper_match;
  logic [1:0]  set_ev;
  logic [1:0]  clr_ev;

  // ****************************************
  // Run and source decode
  // ****************************************
  always_comb
  begin
    cascade = r.lower_timer_control[BIT_CASCADE];
    // Cascade also obeys upper halt bit, so software must clear it
    lower_run = r.lower_timer_control[BIT_COUNT_RUN]
                & ~(idle_mode & r.lower_timer_control[BIT_HALT_IDLE])
                & ~(cascade & idle_mode
                    & r.upper_timer_control[BIT_HALT_IDLE]);
    upper_run = ~cascade & r.upper_timer_control[BIT_COUNT_RUN]
                & ~(idle_mode & r.upper_timer_control[BIT_HALT_IDLE]);
    // Pinless variants fall back to the internal clock
    upper_src = r.upper_timer_control[BIT_CLK_SRC] & UPPER_PIN_PRESENT;
    upper_pin = upper_ext_clock_pin & UPPER_PIN_PRESENT;
  end

  // ****************************************
  // Tick generators
  // ****************************************
  ptc_tick u_lower_tick (
    .clock     (clock),
    .rst_b     (rst_b),
    .ce        (ce),
    .run       (lower_run),
    .ext_sel   (r.lower_timer_control[BIT_CLK_SRC]),
    .gate_en   (r.lower_timer_control[BIT_GATE_EN]),
    .presc_sel (r.lower_timer_control[BIT_PRESC_HI:BIT_PRESC_LO]),
    .ext_pin   (lower_ext_clock_pin),
    .gate_pin  (lower_gate_pin),
    .tick      (lower_tick),
    .gate_fall (lower_gfall)
  );

  ptc_tick u_upper_tick (
    .clock     (clock),
    .rst_b     (rst_b),
    .ce        (ce),
    .run       (upper_run),
    .ext_sel   (upper_src),
    .gate_en   (r.upper_timer_control[BIT_GATE_EN]),
    .presc_sel (r.upper_timer_control[BIT_PRESC_HI:BIT_PRESC_LO]),
    .ext_pin   (upper_pin),
    .gate_pin  (upper_gate_pin),
    .tick      (upper_tick),
    .gate_fall (upper_gfall)
  );

  // ****************************************
  // Count control
  // ****************************************
  always_comb
  begin
    wr_go = psel & penable & pwrite & r.pready;
    lower_load = wr_go & (paddr == ADDR_LOWER_CNT);
    upper_load = wr_go & (paddr == ADDR_UPPER_CNT);
    // Full 32-bit compare in cascade
    match32 = cascade & lower_tick & (lower_cnt == r.lower_period)
              & (upper_cnt == r.upper_period);
    lower_match = ~cascade & lower_tick & (lower_cnt == r.lower_period);
    upper_match = upper_tick & (upper_cnt == r.upper_period);
    lower_inc = lower_tick;
    lower_clr = match32 | lower_match;
    // Lower word carries into upper word
    upper_inc = cascade ? (lower_tick & (lower_cnt == COUNT_MAX)) : upper_tick;
    upper_clr = match32 | upper_match;
    set_ev = 2'b00;
    if (cascade)
    begin
      set_ev[IRQ_UPPER] = match32 | lower_gfall;
    end
    else
    begin
      set_ev[IRQ_LOWER] = lower_match | lower_gfall;
      set_ev[IRQ_UPPER] = upper_match | upper_gfall;
    end
  end

  ptc_count16 u_lower_cnt (
    .clock    (clock),
    .rst_b    (rst_b),
    .ce       (ce),
    .inc      (lower_inc),
    .clr      (lower_clr),
    .load     (lower_load),
    .load_val (pwdata[15:0]),
    .value    (lower_cnt)
  );

  ptc_count16 u_upper_cnt (
    .clock    (clock),
    .rst_b    (rst_b),
    .ce       (ce),
    .inc      (upper_inc),
    .clr      (upper_clr),
    .load     (upper_load),
    .load_val (pwdata[15:0]),
    .value    (upper_cnt)
  );

  // ****************************************
  // APB register file
  // ****************************************
  always_comb
  begin
    next_r = r;
    // One wait state: pready rises the cycle after access starts
    access = psel & penable & ~r.pready;
    unique case (paddr)
      ADDR_LOWER_CTRL,
      ADDR_UPPER_CTRL,
      ADDR_LOWER_PER,
      ADDR_UPPER_PER,
      ADDR_LOWER_CNT,
      ADDR_UPPER_CNT,
      ADDR_IRQ_STAT,
      ADDR_IRQ_CLR,
      ADDR_IRQ_EN: addr_ok = 1'b1;
      default:     addr_ok = 1'b0;
    endcase
    next_r.pready = access;
    if (access)
    begin
      next_r.pslverr = ~addr_ok;
      next_r.prdata = 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (paddr)
          ADDR_LOWER_CTRL: next_r.prdata[15:0] = r.lower_timer_control;
          ADDR_UPPER_CTRL: next_r.prdata[15:0] = r.upper_timer_control;
          ADDR_LOWER_PER:  next_r.prdata[15:0] = r.lower_period;
          ADDR_UPPER_PER:  next_r.prdata[15:0] = r.upper_period;
          ADDR_LOWER_CNT:  next_r.prdata[15:0] = lower_cnt;
          ADDR_UPPER_CNT:  next_r.prdata[15:0] = upper_cnt;
          ADDR_IRQ_STAT:   next_r.prdata[1:0] = r.status;
          ADDR_IRQ_EN:     next_r.prdata[1:0] = r.irq_en;
          default:         next_r.prdata = 32'h0000_0000;
        endcase
      end
    end
    else
    begin
      next_r.pslverr = 1'b0;
    end
    clr_ev = 2'b00;
    if (wr_go)
    begin
      unique case (paddr)
        ADDR_LOWER_CTRL:
        begin
          next_r.lower_timer_control = pwdata[15:0] & LOWER_CTRL_MASK;
        end
        ADDR_UPPER_CTRL:
        begin
          next_r.upper_timer_control = pwdata[15:0] & UPPER_CTRL_MASK;
        end
        ADDR_LOWER_PER:  next_r.lower_period = pwdata[15:0];
        ADDR_UPPER_PER:  next_r.upper_period = pwdata[15:0];
        ADDR_IRQ_CLR:    clr_ev = pwdata[1:0];
        ADDR_IRQ_EN:     next_r.irq_en = pwdata[1:0];
        default:         next_r.irq_en = r.irq_en;
      endcase
    end
    // New event wins over a clear in the same cycle
    next_r.status = (r.status & ~clr_ev) | set_ev;
    next_r.irq = |(next_r.status & next_r.irq_en);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.lower_timer_control <= CTRL_RESET;
      r.upper_timer_control <= CTRL_RESET;
      r.lower_period <= PERIOD_RESET;
      r.upper_period <= PERIOD_RESET;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    pready = r.pready;
    prdata = r.prdata;
    pslverr = r.pslverr;
    irq = r.irq;
  end

endmodule

/* tb/ptc_checker.sv */
`timescale 1ns/1ps
module ptc_checker
  import ptc_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Interrupt
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Bus answer
  // ****************************************
  sequence s_acc; ce && psel && penable && !pready; endsequence
  sequence s_rd; ce && pready && !pwrite; endsequence
  property p_wait; s_acc |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("answer late");
  property p_one; ce && pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_cause; ce && !(psel && penable) |=> !pready; endproperty
  a_cause: assert property (p_cause) else $error("answer unasked");
  property p_unmap;
    pready && paddr > ADDR_IRQ_EN |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped accepted");
  property p_map; pready && paddr <= ADDR_IRQ_EN && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped refused");

  // ****************************************
  // Control readback and reset
  // ****************************************
  property p_lres;
    s_rd ##0 paddr == ADDR_LOWER_CTRL |-> (prdata & {16'hFFFF, ~LOWER_CTRL_MASK}) == 32'h0;
  endproperty
  a_lres: assert property (p_lres) else $error("lower spare bits set");
  property p_ures;
    s_rd ##0 paddr == ADDR_UPPER_CTRL |-> (prdata & {16'hFFFF, ~UPPER_CTRL_MASK}) == 32'h0;
  endproperty
  a_ures: assert property (p_ures) else $error("upper spare bits set");
  property p_rst; $rose(rst_b) |-> !pready && !irq && prdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  // Masking all sources must drop the line within two edges
  property p_mask;
    ce && pready && pwrite && paddr == ADDR_IRQ_EN && pwdata[1:0] == 2'h0 |-> ##2 !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq stays");
  // Enable low freezes pready, prdata and irq
  property p_freeze; !ce |=> $stable(pready) && $stable(prdata) && $stable(irq); endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule

bind ptc_timer_pair ptc_checker chk_u (.clock(clock), .rst_b(rst_b), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .irq(irq));

/* tb/tb.sv */
`timescale 1ns/1ps
module tb
  import ptc_pkg::*;
;
  localparam logic [31:0] RUN  = 32'h0000_8000;
  localparam logic [31:0] HALT = 32'h0000_2000;
  localparam logic [31:0] GATE = 32'h0000_0040;
  localparam logic [31:0] CAS  = 32'h0000_0008;
  localparam logic [31:0] EXT  = 32'h0000_0002;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, irq, rerr, ce;
  logic        idle_mode, lower_ext_clock_pin, upper_ext_clock_pin, lower_gate_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          error_cnt, num_checks, cyc;
  int          wt [4] = '{2, 16, 156, 636};
  logic [31:0] ex [4] = '{32'h6, 32'h2, 32'h2, 32'h2};

  ptc_timer_pair dut_u (.clock(clock), .rst_b(rst_b), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .idle_mode(idle_mode),
    .lower_ext_clock_pin(lower_ext_clock_pin), .upper_ext_clock_pin(upper_ext_clock_pin),
    .lower_gate_pin(lower_gate_pin), .upper_gate_pin(1'b0), .irq(irq));

  initial clock = 1'b0;
  always #50 clock = ~clock;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // Counts for w plus the four cycles of the stopping write
  task automatic run(input logic [7:0] a, input logic [31:0] c, input int w);
    wr(a, c);
    repeat (w) @(posedge clock);
    wr(a, c & ~RUN);
  endtask

  task automatic pulses(input int n, input logic up);
    repeat (n)
    begin
      @(posedge clock);
      if (up)
        upper_ext_clock_pin <= 1'b1;
      else
        lower_ext_clock_pin <= 1'b1;
      repeat (2) @(posedge clock);
      upper_ext_clock_pin <= 1'b0;
      lower_ext_clock_pin <= 1'b0;
      @(posedge clock);
    end
  endtask

  // ****************************************
  // Timeout
  // ****************************************
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    idle_mode = 1'b0;
    lower_ext_clock_pin = 1'b0;
    upper_ext_clock_pin = 1'b0;
    lower_gate_pin = 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rd(ADDR_LOWER_CTRL, 32'h0);
    rd(ADDR_UPPER_CTRL, 32'h0);
    rd(ADDR_LOWER_PER, 32'h0000_FFFF);
    wr(ADDR_LOWER_CTRL, 32'hFFFF_5F85);
    rd(ADDR_LOWER_CTRL, 32'h0);
    wr(ADDR_UPPER_CTRL, 32'hFFFF_FFFF);
    rd(ADDR_UPPER_CTRL, 32'h0000_A072);
    wr(ADDR_UPPER_CTRL, 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_LOWER_CNT, 32'h0);
      run(ADDR_LOWER_CTRL, RUN | 32'(i << 4), wt[i]);
      rd(ADDR_LOWER_CNT, ex[i]);
    end
    // Period of two wraps four times in twelve ticks
    wr(ADDR_LOWER_PER, 32'h2);
    wr(ADDR_LOWER_CNT, 32'h0);
    wr(ADDR_IRQ_EN, 32'h1);
    run(ADDR_LOWER_CTRL, RUN, 8);
    rd(ADDR_LOWER_CNT, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_EN, 32'h0);
    wr(ADDR_IRQ_STAT, 32'h0);
    wr(ADDR_IRQ_CLR, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h0);
    wr(ADDR_LOWER_CTRL, CAS);
    wr(ADDR_UPPER_CNT, 32'h0);
    wr(ADDR_UPPER_CTRL, RUN | 32'h30);
    wr(ADDR_UPPER_PER, 32'h1);
    wr(ADDR_LOWER_PER, 32'h0);
    wr(ADDR_LOWER_CNT, 32'hFFFC);
    rd(ADDR_UPPER_CNT, 32'h0);
    run(ADDR_LOWER_CTRL, CAS | RUN, 0);
    rd(ADDR_UPPER_CNT, 32'h1);
    rd(ADDR_LOWER_CNT, 32'h0);
    run(ADDR_LOWER_CTRL, CAS | RUN, 0);
    rd(ADDR_LOWER_CNT, 32'h3);
    rd(ADDR_IRQ_STAT, 32'h2);
    wr(ADDR_IRQ_CLR, 32'h3);
    wr(ADDR_UPPER_CTRL, 32'h0);
    wr(ADDR_LOWER_CTRL, 32'h0);
    wr(ADDR_LOWER_PER, 32'hFFFF);
    wr(ADDR_UPPER_PER, 32'hFFFF);
    idle_mode <= 1'b1;
    wr(ADDR_LOWER_CNT, 32'h0);
    run(ADDR_LOWER_CTRL, RUN | HALT, 8);
    rd(ADDR_LOWER_CNT, 32'h0);
    run(ADDR_LOWER_CTRL, RUN, 0);
    rd(ADDR_LOWER_CNT, 32'h4);
    // Upper halt bit still stops the joined pair in idle
    wr(ADDR_UPPER_CTRL, HALT);
    run(ADDR_LOWER_CTRL, CAS | RUN, 0);
    rd(ADDR_LOWER_CNT, 32'h4);
    wr(ADDR_UPPER_CTRL, 32'h0);
    run(ADDR_LOWER_CTRL, CAS | RUN, 0);
    rd(ADDR_LOWER_CNT, 32'h8);
    idle_mode <= 1'b0;
    wr(ADDR_LOWER_CNT, 32'h0);
    wr(ADDR_LOWER_CTRL, RUN | EXT | GATE);
    pulses(5, 1'b0);
    wr(ADDR_LOWER_CTRL, 32'h0);
    rd(ADDR_LOWER_CNT, 32'h5);
    wr(ADDR_LOWER_CNT, 32'h0);
    run(ADDR_LOWER_CTRL, RUN | GATE, 8);
    rd(ADDR_LOWER_CNT, 32'h0);
    lower_gate_pin <= 1'b1;
    wr(ADDR_LOWER_CNT, 32'h0);
    run(ADDR_LOWER_CTRL, RUN | GATE, 0);
    rd(ADDR_LOWER_CNT, 32'h4);
    // Gate falling edge raises the lower status bit
    wr(ADDR_LOWER_CTRL, RUN | GATE);
    lower_gate_pin <= 1'b0;
    wr(ADDR_LOWER_CTRL, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_CLR, 32'h1);
    // Ten frozen cycles must add nothing
    wr(ADDR_LOWER_CNT, 32'h0);
    wr(ADDR_LOWER_CTRL, RUN);
    ce <= 1'b0;
    repeat (10) @(posedge clock);
    ce <= 1'b1;
    wr(ADDR_LOWER_CTRL, 32'h0);
    rd(ADDR_LOWER_CNT, 32'h4);
    wr(ADDR_UPPER_CNT, 32'h0);
    wr(ADDR_UPPER_CTRL, RUN | EXT);
    pulses(3, 1'b1);
    wr(ADDR_UPPER_CTRL, 32'h0);
    rd(ADDR_UPPER_CNT, 32'h3);
    run(ADDR_UPPER_CTRL, RUN, 0);
    rd(ADDR_UPPER_CNT, 32'h7);
    // Second reset with both timers stopped clears counts and enables
    wr(ADDR_IRQ_EN, 32'h3);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(ADDR_UPPER_CNT, 32'h0);
    rd(ADDR_IRQ_EN, 32'h0);
    end_of_test();
  end
endmodule
